/* inc/power_loss_pkg.sv */
package power_loss_pkg;

    // ------------------------------------------------------------
    // function switch word one layout
    // ------------------------------------------------------------
    localparam int SWITCH_WIDTH = 16;
    localparam int RECOVERY_BIT = 5;
    localparam logic [15:0] SWITCH_RESET = 16'h0000;

    // ------------------------------------------------------------
    // alarm codes and trace log
    // ------------------------------------------------------------
    localparam int CODE_WIDTH = 8;
    localparam logic [7:0] POWER_LOSS_CODE = 8'hf3;
    localparam logic [7:0] NO_ALARM_CODE = 8'h00;
    localparam int LOG_DEPTH = 10;
    localparam int LOG_INDEX_WIDTH = 4;

    // ------------------------------------------------------------
    // power holding time
    // ------------------------------------------------------------
    localparam int CLOCK_HZ = 20_000_000;
    localparam int HOLD_TIME_MS = 100;
    localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLOCK_HZ / 1000);

endpackage : power_loss_pkg

/* hw/alarm_trace_memory.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// alarm trace memory: ring of alarm codes with registered read
// ------------------------------------------------------------
module alarm_trace_memory
    import power_loss_pkg::*;
#(
    parameter int DEPTH = LOG_DEPTH,
    parameter int WIDTH = CODE_WIDTH,
    parameter int INDEX_WIDTH = LOG_INDEX_WIDTH
) (
    input wire logic clock,
    input wire logic write_enable,
    input wire logic [INDEX_WIDTH-1:0] write_index,
    input wire logic [WIDTH-1:0] write_data,
    input wire logic [INDEX_WIDTH-1:0] read_index,
    output logic [WIDTH-1:0] read_data
);

    logic [WIDTH-1:0] cells [DEPTH];

    // one generate entry per cell; unwritten cells hold power-up junk
    // which the caller hides behind its entry count
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        always_ff @(posedge clock) begin
            if (write_enable && write_index == INDEX_WIDTH'(i)) begin
                cells[i] <= write_data;
            end
        end
    end

    // registered read; out-of-range index reads as zero
    always_ff @(posedge clock) begin
        if (read_index < INDEX_WIDTH'(DEPTH)) begin
            read_data <= cells[read_index];
        end else begin
            read_data <= '0;
        end
    end

endmodule : alarm_trace_memory

/* hw/power_loss_alarm_handler.sv */
`timescale 1ns/1ps

module power_loss_alarm_handler
    import power_loss_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES,
    parameter int DEPTH = LOG_DEPTH
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic power_on_reset_n,
    input wire logic voltage_drop,
    input wire logic other_alarm,
    input wire logic [CODE_WIDTH-1:0] other_alarm_code,
    input wire logic alarm_reset,
    input wire logic switch_write,
    input wire logic [SWITCH_WIDTH-1:0] switch_write_data,
    input wire logic log_read,
    input wire logic [LOG_INDEX_WIDTH-1:0] log_read_index,
    output logic fault_indicator_output_n,
    output logic [CODE_WIDTH-1:0] alarm_code,
    output logic power_loss_alarm,
    output logic stop_request,
    output logic [SWITCH_WIDTH-1:0] function_switch_word_one,
    output logic [SWITCH_WIDTH-1:0] active_switch_word,
    output logic [LOG_INDEX_WIDTH-1:0] log_count,
    output logic [CODE_WIDTH-1:0] log_read_data,
    output logic log_read_valid
);

    // ------------------------------------------------------------
    // pin synchroniser for the voltage-drop detector
    // ------------------------------------------------------------
    logic drop_meta;
    logic drop_sync_a;
    logic drop_sync_b;
    logic drop_level;

    // three stages; a change counts once the last two agree
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            drop_meta <= 1'b0;
            drop_sync_a <= 1'b0;
            drop_sync_b <= 1'b0;
            drop_level <= 1'b0;
        end else begin
            drop_meta <= voltage_drop;
            drop_sync_a <= drop_meta;
            drop_sync_b <= drop_sync_a;
            if (drop_sync_a == drop_sync_b) begin
                drop_level <= drop_sync_b;
            end
        end
    end

    logic drop_rise;
    logic drop_fall;
    assign drop_rise = drop_sync_a && drop_sync_b && !drop_level;
    assign drop_fall = !drop_sync_a && !drop_sync_b && drop_level;

    // ------------------------------------------------------------
    // function switch words
    // ------------------------------------------------------------
    logic recovery_clears;
    assign recovery_clears = active_switch_word[RECOVERY_BIT];

    // written word shows at once; the active copy moves only on a true
    // power-on reset, so a quick repower keeps the old setting
    always_ff @(posedge clock) begin
        if (!power_on_reset_n) begin
            active_switch_word <= function_switch_word_one;
        end
    end

    // the written copy survives a warm reset like non-volatile storage
    always_ff @(posedge clock) begin
        if (!power_on_reset_n && function_switch_word_one === 'x) begin
            function_switch_word_one <= SWITCH_RESET;
        end else if (switch_write) begin
            function_switch_word_one <= switch_write_data;
        end
    end

    // ------------------------------------------------------------
    // power holding timer
    // ------------------------------------------------------------
    logic [31:0] hold_count;
    logic hold_expired;

    // counts while supply is low; expiry means a real power-off
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hold_count <= '0;
            hold_expired <= 1'b0;
        end else if (!drop_level) begin
            hold_count <= '0;
            hold_expired <= 1'b0;
        end else if (hold_count < 32'(HOLD_COUNT)) begin
            hold_count <= hold_count + 32'h1;
        end else begin
            hold_expired <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // alarm latch
    // ------------------------------------------------------------
    logic next_power_loss;
    logic new_other;
    assign new_other = other_alarm && alarm_code == NO_ALARM_CODE;

    // set wins over clear; the drop edge latches at once
    always_comb begin
        next_power_loss = power_loss_alarm;
        if (alarm_reset && !drop_level) begin
            next_power_loss = 1'b0;
        end
        if (drop_fall && recovery_clears && !hold_expired) begin
            next_power_loss = 1'b0;
        end
        if (drop_rise) begin
            next_power_loss = 1'b1;
        end
    end

    // with the recovery bit low only reset_n, or an alarm reset once the drop has gone, clears it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            power_loss_alarm <= 1'b0;
        end else begin
            power_loss_alarm <= next_power_loss;
        end
    end

    // active alarm code and inverted output drive
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            alarm_code <= NO_ALARM_CODE;
            fault_indicator_output_n <= 1'b1;
            stop_request <= 1'b0;
        end else begin
            if (next_power_loss) begin
                alarm_code <= POWER_LOSS_CODE;
            end else if (new_other) begin
                alarm_code <= other_alarm_code;
            end else if (alarm_reset || alarm_code == POWER_LOSS_CODE) begin
                alarm_code <= NO_ALARM_CODE;
            end
            fault_indicator_output_n <= !(next_power_loss
                || new_other
                || (alarm_code != NO_ALARM_CODE
                    && alarm_code != POWER_LOSS_CODE
                    && !alarm_reset));
            stop_request <= next_power_loss || other_alarm;
        end
    end

    // ------------------------------------------------------------
    // trace log
    // ------------------------------------------------------------
    logic [LOG_INDEX_WIDTH-1:0] write_pointer;
    logic log_write;
    logic [CODE_WIDTH-1:0] log_data;

    // power loss is logged only when it is held on recovery
    assign log_write = (drop_rise && !recovery_clears)
        || (new_other && !drop_rise);
    assign log_data = drop_rise ? POWER_LOSS_CODE : other_alarm_code;

    // ring pointer wraps so a full log overwrites the oldest entry
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            write_pointer <= '0;
            log_count <= '0;
        end else if (log_write) begin
            if (write_pointer == LOG_INDEX_WIDTH'(DEPTH - 1)) begin
                write_pointer <= '0;
            end else begin
                write_pointer <= write_pointer + LOG_INDEX_WIDTH'(1);
            end
            if (log_count < LOG_INDEX_WIDTH'(DEPTH)) begin
                log_count <= log_count + LOG_INDEX_WIDTH'(1);
            end
        end
    end

    // read index 0 is the newest entry; map it to the ring slot
    logic [LOG_INDEX_WIDTH:0] slot_sum;
    logic [LOG_INDEX_WIDTH-1:0] read_slot;
    logic [CODE_WIDTH-1:0] memory_data;
    logic read_in_range;
    logic read_pending;

    always_comb begin
        slot_sum = {1'b0, write_pointer} + LOG_INDEX_WIDTH'(DEPTH - 1)
            - {1'b0, log_read_index};
        if (slot_sum >= (LOG_INDEX_WIDTH + 1)'(DEPTH)) begin
            read_slot = slot_sum[LOG_INDEX_WIDTH-1:0]
                - LOG_INDEX_WIDTH'(DEPTH);
        end else begin
            read_slot = slot_sum[LOG_INDEX_WIDTH-1:0];
        end
    end

    alarm_trace_memory #(
        .DEPTH(DEPTH),
        .WIDTH(CODE_WIDTH),
        .INDEX_WIDTH(LOG_INDEX_WIDTH)
    ) u_alarm_trace_memory (
        .clock(clock),
        .write_enable(log_write),
        .write_index(write_pointer),
        .write_data(log_data),
        .read_index(read_slot),
        .read_data(memory_data)
    );

    // terminal read: answer two cycles after the request
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            read_in_range <= 1'b0;
            read_pending <= 1'b0;
            log_read_data <= NO_ALARM_CODE;
            log_read_valid <= 1'b0;
        end else begin
            read_pending <= log_read;
            read_in_range <= log_read_index < log_count;
            log_read_valid <= read_pending;
            if (read_pending) begin
                log_read_data <= read_in_range ? memory_data : NO_ALARM_CODE;
            end
        end
    end

endmodule : power_loss_alarm_handler

/* bench/power_loss_alarm_handler_assertions.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// port checker for the power-loss alarm handler
// ------------------------------------------------------------
module power_loss_alarm_handler_assertions
    import power_loss_pkg::*;
#(
    parameter int DEPTH = LOG_DEPTH
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic alarm_reset,
    input wire logic log_read,
    input wire logic fault_indicator_output_n,
    input wire logic [CODE_WIDTH-1:0] alarm_code,
    input wire logic power_loss_alarm,
    input wire logic stop_request,
    input wire logic [SWITCH_WIDTH-1:0] active_switch_word,
    input wire logic [LOG_INDEX_WIDTH-1:0] log_count,
    input wire logic log_read_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // a read request answered two cycles later
    sequence s_req;
        log_read;
    endsequence
    sequence s_answer;
        ##2 log_read_valid;
    endsequence

    property p_code;
        $rose(power_loss_alarm) |-> alarm_code == POWER_LOSS_CODE;
    endproperty
    a_code: assert property (p_code)
        else $error("power loss code wrong");
    property p_stop;
        power_loss_alarm |-> stop_request;
    endproperty
    a_stop: assert property (p_stop)
        else $error("no stop during power loss");
    property p_ind;
        power_loss_alarm |-> !fault_indicator_output_n;
    endproperty
    a_ind: assert property (p_ind)
        else $error("indicator high during alarm");
    // holding mode keeps the latch until an explicit reset
    property p_hold;
        power_loss_alarm && !active_switch_word[RECOVERY_BIT]
            && !alarm_reset |=> power_loss_alarm;
    endproperty
    a_hold: assert property (p_hold)
        else $error("held alarm dropped");
    property p_nolog;
        $rose(power_loss_alarm) && active_switch_word[RECOVERY_BIT]
            |-> $stable(log_count);
    endproperty
    a_nolog: assert property (p_nolog)
        else $error("power loss logged in clear mode");
    property p_log;
        $rose(power_loss_alarm) && !active_switch_word[RECOVERY_BIT]
            && $past(log_count) < DEPTH
            |-> log_count == $past(log_count) + 1;
    endproperty
    a_log: assert property (p_log)
        else $error("log not updated with latch");
    property p_depth;
        log_count <= DEPTH;
    endproperty
    a_depth: assert property (p_depth)
        else $error("log count above depth");
    property p_read;
        s_req |-> s_answer;
    endproperty
    a_read: assert property (p_read)
        else $error("log read not answered");
endmodule : power_loss_alarm_handler_assertions

/* bench/host_reader.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side: strobes log reads, watches the alarm line
// ------------------------------------------------------------
module host_reader
    import power_loss_pkg::*;
(
    input wire logic clock,
    input wire logic req,
    input wire logic [LOG_INDEX_WIDTH-1:0] req_index,
    input wire logic fault_indicator_output_n,
    output logic log_read,
    output logic [LOG_INDEX_WIDTH-1:0] log_read_index,
    output logic alarm_seen
);
    // index follows the request so it is steady while strobed
    always_ff @(posedge clock) begin
        log_read <= req;
        log_read_index <= req_index;
        alarm_seen <= !fault_indicator_output_n;
    end
endmodule : host_reader

/* bench/power_loss_alarm_handler_bench.sv */
`timescale 1ns/1ps

module power_loss_alarm_handler_bench;
    import power_loss_pkg::*;
    localparam int HOLD = 20;
    logic clock, reset_n, por_n, drop, oa, clr, sw_wr, req, lr, lv, seen;
    logic [7:0] oa_code, code, rdat;
    logic [15:0] sw_data, sw, word, active;
    logic [3:0] req_index, lr_index, count;
    logic ind_n, pla, stop;
    logic [7:0] codes[11];
    logic [7:0] exp_q[$];
    int fails = 0;
    int num_checks = 0;

    power_loss_alarm_handler #(.HOLD_COUNT(HOLD), .DEPTH(LOG_DEPTH))
    u_power_loss_alarm_handler (.clock(clock), .reset_n(reset_n),
        .power_on_reset_n(por_n), .voltage_drop(drop), .other_alarm(oa),
        .other_alarm_code(oa_code), .alarm_reset(clr),
        .switch_write(sw_wr), .switch_write_data(sw_data),
        .log_read(lr), .log_read_index(lr_index),
        .fault_indicator_output_n(ind_n), .alarm_code(code),
        .power_loss_alarm(pla), .stop_request(stop),
        .function_switch_word_one(word), .active_switch_word(active),
        .log_count(count), .log_read_data(rdat), .log_read_valid(lv));
    host_reader u_host_reader (.clock(clock), .req(req),
        .req_index(req_index), .fault_indicator_output_n(ind_n),
        .log_read(lr), .log_read_index(lr_index), .alarm_seen(seen));

    task automatic chk(input string what, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick
    // bounded wait for the latch; a hang ends the run
    task automatic wait_alarm(input logic lvl);
        int n = 0;
        while (pla !== lvl && n < 40) begin
            tick(1);
            n++;
        end
        if (pla !== lvl) begin
            chk("alarm wait", 16'(lvl), 16'(pla));
            conclude();
        end
    endtask : wait_alarm
    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        req_index = idx;
        req = 1'b1;
        tick(1);
        req = 1'b0;
        tick(3);
    endtask : rd
    task automatic pulse_clr();
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(2);
    endtask : pulse_clr
    task automatic por();
        reset_n = 1'b0;
        por_n = 1'b0;
        tick(5);
        reset_n = 1'b1;
        por_n = 1'b1;
        tick(1);
    endtask : por

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // read answers are matched in request order; looked at mid-cycle
    // so the registered answer has settled, and an answer nobody asked
    // for counts as a mismatch instead of matching a default zero
    always @(negedge clock) begin
        if (lv === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected log_read_valid", 16'h0, 16'h1);
            end else begin
                chk("log_read_data", exp_q.pop_front(), rdat);
            end
        end
    end

    initial begin
        {drop, oa, clr, sw_wr, req, oa_code, sw_data, req_index} = '0;
        void'($urandom(60));
        por();
        // ----------------------------------------------------------
        // holding mode
        // ----------------------------------------------------------
        chk("active", SWITCH_RESET, active);
        drop = 1'b1;
        wait_alarm(1'b1);
        tick(1);
        chk("code", POWER_LOSS_CODE, code);
        chk("stop", 16'h1, stop);
        chk("host view", 16'h1, seen);
        chk("count", 16'h1, count);
        drop = 1'b0;
        tick(HOLD + 10);
        chk("held", 16'h1, pla);
        chk("indicator", 16'h0, ind_n);
        rd(4'h0, POWER_LOSS_CODE);
        rd(4'h1, NO_ALARM_CODE);
        pulse_clr();
        chk("indicator", 16'h1, ind_n);
        $display("test hold done");
        // ----------------------------------------------------------
        // switch change waits for power-on reset, then clear mode
        // ----------------------------------------------------------
        sw = 16'($urandom) | 16'h0020;
        sw_data = sw;
        sw_wr = 1'b1;
        tick(1);
        sw_wr = 1'b0;
        tick(2);
        chk("shown", sw, word);
        chk("in use", SWITCH_RESET, active);
        por();
        chk("in use", sw, active);
        drop = 1'b1;
        wait_alarm(1'b1);
        chk("count", 16'h0, count);
        drop = 1'b0;
        wait_alarm(1'b0);
        chk("indicator", 16'h1, ind_n);
        chk("in use", sw, active);
        $display("test recover done");
        // ----------------------------------------------------------
        // a drop that outlasts the holding time stays latched
        // ----------------------------------------------------------
        drop = 1'b1;
        wait_alarm(1'b1);
        tick(HOLD + 10);
        drop = 1'b0;
        tick(10);
        chk("expired", 16'h1, pla);
        chk("indicator", 16'h0, ind_n);
        pulse_clr();
        chk("cleared", 16'h0, pla);
        chk("count", 16'h0, count);
        $display("test expiry done");
        // ----------------------------------------------------------
        // eleven other alarms overflow the ten-entry log
        // ----------------------------------------------------------
        for (int i = 0; i < 11; i++) begin
            codes[i] = {1'b0, 7'($urandom)} | 8'h01;
            oa_code = codes[i];
            oa = 1'b1;
            tick(2);
            chk("indicator", 16'h0, ind_n);
            chk("code", codes[i], code);
            oa = 1'b0;
            pulse_clr();
        end
        chk("count", 16'(LOG_DEPTH), count);
        rd(4'h0, codes[10]);
        rd(4'h9, codes[1]);
        $display("test log done");
        chk("reads left", 16'h0, 16'(exp_q.size()));
        conclude();
    end
endmodule : power_loss_alarm_handler_bench

bind power_loss_alarm_handler power_loss_alarm_handler_assertions
    #(.DEPTH(DEPTH)) u_power_loss_alarm_handler_assertions (
    .clock(clock), .reset_n(reset_n), .alarm_reset(alarm_reset),
    .log_read(log_read),
    .fault_indicator_output_n(fault_indicator_output_n),
    .alarm_code(alarm_code), .power_loss_alarm(power_loss_alarm),
    .stop_request(stop_request), .active_switch_word(active_switch_word),
    .log_count(log_count), .log_read_valid(log_read_valid));
